// [src/bridge_legacy_pkg.sv]
// Constants shared by the legacy decode and error control block.
// Assumes the configuration writer owns the command and window registers.
package bridge_legacy_pkg;
   // ----------------------------------------
   // Bridge control field positions
   // ----------------------------------------
   localparam int BC_PARITY_RESP_BIT = 0;
   localparam int BC_SYSERR_FWD_BIT = 1;
   localparam int BC_IO_ALIAS_BIT = 2;
   localparam int BC_VIDEO_EN_BIT = 3;
   localparam int BC_FULL_DECODE_BIT = 4;
   localparam logic [15:0] BC_WRITE_MASK = 16'h001F;
   localparam logic [15:0] BC_RESET = 16'h0000;
   // ----------------------------------------
   // Command register field positions
   // ----------------------------------------
   localparam int CMD_IO_EN_BIT = 0;
   localparam int CMD_MEM_EN_BIT = 1;
   localparam int CMD_SYSERR_EN_BIT = 8;
   // ----------------------------------------
   // Legacy display address ranges
   // ----------------------------------------
   localparam logic [31:0] VID_MEM_LO = 32'h000A_0000;
   localparam logic [31:0] VID_MEM_HI = 32'h000B_FFFF;
   localparam logic [9:0] VID_IO_A_LO = 10'h3B0;
   localparam logic [9:0] VID_IO_A_HI = 10'h3BB;
   localparam logic [9:0] VID_IO_B_LO = 10'h3C0;
   localparam logic [9:0] VID_IO_B_HI = 10'h3DF;
   // Low 256 bytes of each 1 KB block are never alias-blocked
   localparam logic [1:0] ALIAS_FREE_QUARTER = 2'h0;
endpackage

// [src/bridge_decode_if.sv]
// Interface carrying one decode request and its verdict.
// Assumes one transaction is presented per cycle.
`timescale 1ns/10ps
`default_nettype none
interface bridge_decode_if;
   logic [31:0] addr;
   logic is_io;
   logic upstream;
   logic in_io_win;
   logic in_mem_win;
   logic forward;
   modport req (output addr, is_io, upstream, in_io_win, in_mem_win, input forward);
   modport dec (input addr, is_io, upstream, in_io_win, in_mem_win, output forward);
endinterface // bridge_decode_if
`default_nettype wire

// [src/bridge_addr_decode.sv]
// Combinational forwarding decision for one address.
// Assumes window hits are computed by the caller.
`timescale 1ns/10ps
`default_nettype none
module bridge_addr_decode
   import bridge_legacy_pkg::*;
(
   bridge_decode_if.dec d,
   input wire logic [15:0] bctl,
   input wire logic [15:0] cmd
);
   logic vid_en;
   logic vid_hit;
   logic alias_zone;
   logic low64k;
   assign vid_en = bctl[BC_VIDEO_EN_BIT];
   assign low64k = (d.addr[31:16] == 16'h0000);
   // Legacy display hit, full decode optional
   always_comb
   begin
      if (d.is_io)
      begin
         vid_hit = low64k &&
            (((d.addr[9:0] >= VID_IO_A_LO) && (d.addr[9:0] <= VID_IO_A_HI)) ||
             ((d.addr[9:0] >= VID_IO_B_LO) && (d.addr[9:0] <= VID_IO_B_HI))) &&
            (!bctl[BC_FULL_DECODE_BIT] || (d.addr[15:10] == 6'h00));
      end
      else
      begin
         vid_hit = (d.addr >= VID_MEM_LO) && (d.addr <= VID_MEM_HI);
      end
   end
   assign alias_zone = bctl[BC_IO_ALIAS_BIT] && low64k && d.in_io_win &&
      (d.addr[9:8] != ALIAS_FREE_QUARTER);
   always_comb
   begin
      if (vid_en && vid_hit)
      begin
         // Window and alias settings do not matter here
         d.forward = !d.upstream && (d.is_io ? cmd[CMD_IO_EN_BIT]
            : cmd[CMD_MEM_EN_BIT]);
      end
      else if (d.upstream)
      begin
         d.forward = d.is_io ? (!d.in_io_win || alias_zone)
            : !d.in_mem_win;
      end
      else if (d.is_io)
      begin
         d.forward = cmd[CMD_IO_EN_BIT] && d.in_io_win && !alias_zone;
      end
      else
      begin
         d.forward = cmd[CMD_MEM_EN_BIT] && d.in_mem_win;
      end
   end
endmodule // bridge_addr_decode
`default_nettype wire

// [src/bridge_err_fwd.sv]
// Secondary error forwarding and poisoning decisions.
// Assumes error inputs are one-cycle event pulses.
`timescale 1ns/10ps
`default_nettype none
module bridge_err_fwd
   import bridge_legacy_pkg::*;
(
   input wire logic [15:0] bctl,
   input wire logic [15:0] cmd,
   input wire logic sec_syserr,
   input wire logic sec_addr_err,
   input wire logic sec_attr_err,
   input wire logic sec_data_err,
   output logic syserr_fwd,
   output logic parity_report,
   output logic poison
);
   assign syserr_fwd = bctl[BC_SYSERR_FWD_BIT] && cmd[CMD_SYSERR_EN_BIT] &&
      sec_syserr;
   assign parity_report = bctl[BC_PARITY_RESP_BIT] &&
      (sec_addr_err || sec_attr_err || sec_data_err);
   // Poison does not look at the response bit
   assign poison = sec_data_err;
endmodule // bridge_err_fwd
`default_nettype wire

// [src/bridge_legacy_decode_error_ctrl.sv]
// Legacy display decode, I/O alias blocking and secondary error control.
// Assumes config writes and transaction lookups arrive synchronous to CLK_SYS.
`timescale 1ns/10ps
`default_nettype none
module bridge_legacy_decode_error_ctrl
   import bridge_legacy_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // Bridge control register port
   input wire logic BCTL_WR,
   input wire logic [15:0] BCTL_WDATA,
   output logic [15:0] BCTL_RDATA,
   // Command register copy
   input wire logic [15:0] CMD_REG,
   // Transaction lookup
   input wire logic LOOKUP_VALID,
   input wire logic [31:0] LOOKUP_ADDR,
   input wire logic LOOKUP_IS_IO,
   input wire logic LOOKUP_UPSTREAM,
   input wire logic LOOKUP_IN_IO_WIN,
   input wire logic LOOKUP_IN_MEM_WIN,
   output logic LOOKUP_DONE,
   output logic LOOKUP_FORWARD,
   // Secondary error events
   input wire logic SEC_SYSERR,
   input wire logic SEC_ADDR_ERR,
   input wire logic SEC_ATTR_ERR,
   input wire logic SEC_DATA_ERR,
   output logic SYSERR_UPSTREAM,
   output logic PARITY_ERR_REPORT,
   output logic POISON_DATA
);
   // ----------------------------------------
   // Bridge control register
   // ----------------------------------------
   logic [15:0] bridge_control;
   always_ff @(posedge CLK_SYS or posedge SYS_RST)
   begin
      if (SYS_RST)
         bridge_control <= BC_RESET;
      else if (BCTL_WR)
         bridge_control <= BCTL_WDATA & BC_WRITE_MASK;
   end
   always_ff @(posedge CLK_SYS or posedge SYS_RST)
   begin
      if (SYS_RST)
         BCTL_RDATA <= BC_RESET;
      else
         BCTL_RDATA <= bridge_control;
   end
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   bridge_decode_if dif ();
   assign dif.addr = LOOKUP_ADDR;
   assign dif.is_io = LOOKUP_IS_IO;
   assign dif.upstream = LOOKUP_UPSTREAM;
   assign dif.in_io_win = LOOKUP_IN_IO_WIN;
   assign dif.in_mem_win = LOOKUP_IN_MEM_WIN;
   bridge_addr_decode u_dec (
      .d(dif),
      .bctl(bridge_control),
      .cmd(CMD_REG)
   );
   // Registered verdict, one cycle after the lookup
   always_ff @(posedge CLK_SYS or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         LOOKUP_DONE <= 1'b0;
         LOOKUP_FORWARD <= 1'b0;
      end
      else
      begin
         LOOKUP_DONE <= LOOKUP_VALID;
         LOOKUP_FORWARD <= LOOKUP_VALID && dif.forward;
      end
   end
   // ----------------------------------------
   // Error forwarding
   // ----------------------------------------
   logic syserr_fwd;
   logic parity_report;
   logic poison;
   bridge_err_fwd u_err (
      .bctl(bridge_control),
      .cmd(CMD_REG),
      .sec_syserr(SEC_SYSERR),
      .sec_addr_err(SEC_ADDR_ERR),
      .sec_attr_err(SEC_ATTR_ERR),
      .sec_data_err(SEC_DATA_ERR),
      .syserr_fwd(syserr_fwd),
      .parity_report(parity_report),
      .poison(poison)
   );
   always_ff @(posedge CLK_SYS or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         SYSERR_UPSTREAM <= 1'b0;
         PARITY_ERR_REPORT <= 1'b0;
         POISON_DATA <= 1'b0;
      end
      else
      begin
         SYSERR_UPSTREAM <= syserr_fwd;
         PARITY_ERR_REPORT <= parity_report;
         POISON_DATA <= poison;
      end
   end
endmodule // bridge_legacy_decode_error_ctrl
`default_nettype wire

// [test/sec_bus_model.sv]
// Secondary bus stand-in raising error events.
// Assumes the bench holds fire for one cycle per event.
`timescale 1ns/10ps
`default_nettype none
module sec_bus_model
(
   input wire logic fire,
   input wire logic [3:0] kind,
   output logic syserr, addr_err, attr_err, data_err
);
   // Quiet outside a fired cycle, so events stay single pulses
   assign {data_err, attr_err, addr_err, syserr} = fire ? kind : 4'h0;
endmodule // sec_bus_model
`default_nettype wire

// [test/bridge_legacy_properties.sv]
// Port checks for the legacy decode and error block.
// Assumes config is not written in the cycle before a lookup.
`timescale 1ns/10ps
`default_nettype none
module bridge_legacy_props
   import bridge_legacy_pkg::*;
(
   input wire logic CLK_SYS, SYS_RST, BCTL_WR, LOOKUP_VALID, LOOKUP_IS_IO,
   input wire logic LOOKUP_UPSTREAM, LOOKUP_FORWARD, SEC_SYSERR, SEC_ADDR_ERR,
   input wire logic SEC_ATTR_ERR, SEC_DATA_ERR, SYSERR_UPSTREAM, PARITY_ERR_REPORT,
   input wire logic POISON_DATA,
   input wire logic [15:0] BCTL_WDATA, BCTL_RDATA, CMD_REG,
   input wire logic [31:0] LOOKUP_ADDR
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   // Readback lags the store by one edge
   sequence s_wr_seen;
      ##2 BCTL_RDATA == ($past(BCTL_WDATA, 2) & BC_WRITE_MASK);
   endsequence
   chk_wr_readback: assert property (BCTL_WR |-> s_wr_seen)
      else $error("readback wrong");
   chk_poison_always: assert property (SEC_DATA_ERR |=> POISON_DATA)
      else $error("poison missing");
   chk_syserr_cause: assert property (SYSERR_UPSTREAM |-> $past(SEC_SYSERR & CMD_REG[8]))
      else $error("syserr without cause");
   chk_syserr_off: assert property (!BCTL_RDATA[1] && !$past(BCTL_WR) |=> !SYSERR_UPSTREAM)
      else $error("syserr while off");
   chk_parity_seen: assert property (BCTL_RDATA[0] && !$past(BCTL_WR)
      && (SEC_ADDR_ERR || SEC_ATTR_ERR || SEC_DATA_ERR) |=> PARITY_ERR_REPORT)
      else $error("parity unreported");
   chk_parity_off: assert property (!BCTL_RDATA[0] && !$past(BCTL_WR) |=> !PARITY_ERR_REPORT)
      else $error("parity while off");
   chk_video_up_block: assert property (LOOKUP_VALID && !$past(BCTL_WR) && BCTL_RDATA[3]
      && LOOKUP_UPSTREAM && !LOOKUP_IS_IO && LOOKUP_ADDR[31:17] == 15'h0005 |=> !LOOKUP_FORWARD)
      else $error("display memory went up");
   chk_video_io_claim: assert property (LOOKUP_VALID && !$past(BCTL_WR)
      && BCTL_RDATA[4:3] == 2'h1 && LOOKUP_IS_IO && !LOOKUP_UPSTREAM && CMD_REG[0]
      && LOOKUP_ADDR[31:16] == 16'h0000 && LOOKUP_ADDR[9:5] == 5'h1E |=> LOOKUP_FORWARD)
      else $error("display io not claimed");
endmodule // bridge_legacy_props
bind bridge_legacy_decode_error_ctrl bridge_legacy_props i_props (.*);
`default_nettype wire

// [test/tb_top.sv]
// Random and corner lookups with error events.
// Assumes registered answers one cycle after each request.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import bridge_legacy_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, valid = 1'b0, io = 1'b0, up = 1'b0;
   logic iow = 1'b0, memw = 1'b0, fire = 1'b0, done, fwd, sy_up, par, poison, se, ae, te, de;
   logic [3:0] kind = 4'h0;
   logic [15:0] wdata = 16'h0000, cmd = 16'h0000, rdata;
   logic [31:0] addr = 32'h0000_0000, r = 32'h0000_5C98;
   logic [31:0] corner [8] = '{32'h0009_FFFF, 32'h000A_0000, 32'h000B_FFFF, 32'h000C_0000,
      32'h0000_03BB, 32'h0000_03BC, 32'h0000_F3DF, 32'h0001_03C4};
   int error_cnt = 0, num_checks = 0;
   always #25 clk = ~clk;
   sec_bus_model i_sec (.fire(fire), .kind(kind), .syserr(se), .addr_err(ae), .attr_err(te),
      .data_err(de));
   bridge_legacy_decode_error_ctrl i_dut (.CLK_SYS(clk), .SYS_RST(rst), .BCTL_WR(wr),
      .BCTL_WDATA(wdata), .BCTL_RDATA(rdata), .CMD_REG(cmd), .LOOKUP_VALID(valid),
      .LOOKUP_ADDR(addr), .LOOKUP_IS_IO(io), .LOOKUP_UPSTREAM(up), .LOOKUP_IN_IO_WIN(iow),
      .LOOKUP_IN_MEM_WIN(memw), .LOOKUP_DONE(done), .LOOKUP_FORWARD(fwd), .SEC_SYSERR(se),
      .SEC_ADDR_ERR(ae), .SEC_ATTR_ERR(te), .SEC_DATA_ERR(de), .SYSERR_UPSTREAM(sy_up),
      .PARITY_ERR_REPORT(par), .POISON_DATA(poison));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic fwd_exp(input logic [15:0] b, input logic [31:0] a);
      logic vid, hit;
      vid = b[3] && (io ? a[31:16] == 16'h0000 && (!b[4] || a[15:10] == 6'h00)
         && ((a[9:0] >= VID_IO_A_LO && a[9:0] <= VID_IO_A_HI)
         || (a[9:0] >= VID_IO_B_LO && a[9:0] <= VID_IO_B_HI))
         : a >= VID_MEM_LO && a <= VID_MEM_HI);
      hit = b[2] && io && iow && a[31:16] == 16'h0000 && a[9:8] != 2'h0;
      if (vid)
         return !up && (io ? cmd[0] : cmd[1]);
      if (up)
         return hit || (io ? !iow : !memw);
      return io ? cmd[0] && iow && !hit : cmd[1] && memw;
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset", rdata, BC_RESET);
      // First eight passes force video decode on with boundary addresses
      for (int i = 0; i < 200; i++)
      begin
         r = xs(r);
         @(posedge clk);
         wr <= 1'b1;
         wdata <= r[15:0] | (i < 8 ? 16'h0008 : 16'h0000);
         // Answers stand one cycle only; no lookup or event was sampled here
         #1 chk("quiet", {done, fwd, sy_up, par, poison}, 5'h00);
         @(posedge clk);
         wr <= 1'b0;
         r = xs(r);
         @(posedge clk);
         valid <= 1'b1;
         fire <= 1'b1;
         kind <= r[3:0];
         cmd <= {7'h00, r[4], 6'h00, r[6:5]};
         up <= r[7];
         iow <= r[8];
         memw <= r[9];
         io <= i < 8 ? !corner[i][19] : r[31];
         addr <= i < 8 ? corner[i] : r[31] ? {15'h0, r[30] & r[29], r[28] ? 6'h00 : r[15:10],
            r[27] ? 2'h3 : r[9:8], r[7:0]} : 32'h0009_F000 + {14'h0, r[31:14]};
         @(posedge clk);
         valid <= 1'b0;
         fire <= 1'b0;
         #1 chk("done", done, 1'b1);
         if (io)
            chk("io_fwd", fwd, fwd_exp(wdata, addr));
         else
            chk("mem_fwd", fwd, fwd_exp(wdata, addr));
         chk("rdata", rdata, wdata & BC_WRITE_MASK);
         chk("syserr", sy_up, wdata[1] & cmd[8] & kind[0]);
         chk("parity", par, wdata[0] & |kind[3:1]);
         chk("poison", poison, kind[3]);
      end
      results();
   end
   initial
   begin
      repeat (2000) @(posedge clk);
      error_cnt++;
      results();
   end
endmodule // tb_top
`default_nettype wire
